//--- cdvsp_top.sv
// cdvsp_top: write-only two-wire serial target with coil settings
// assumes an open-drain data pin resolved outside; scl is never driven
//
// Function
// - data is stable while clock high; changes only while clock low.
// - both lines rest high when idle; receiver idles, never drives.
// - data falling while clock high is a start; begins frame reception.
// - data rising while clock high is a stop; closes the frame.
// - bytes are eight bits, shifted in one bit per clock rise.
// - write only; device never returns data bytes.
// - after 8th bit clock fall, device pulls data low to acknowledge.
// - device releases data on the fall ending the ninth pulse.
// - a standard frame is address plus three configuration bytes.
// - device answers address 0110011 with write direction bit 0.
// - byte 2: standby, spare, code 9..4; byte 3 high nibble code 3..0.
// - byte 4: step size select 7..5, step time select 4..2.
// - standby bit written 1 puts device in standby, stops operation.
// - enable pin low clears standby bit and current code to zero.
// - enable low, standby set, or code zero forces output off.
// - step period 0.032 ms doubling per time code; size sets increment.
`timescale 1ns/1ps
module cdvsp_top
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rstn,
  // serial pins
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output      logic                        sda_out,
  output      logic                        sda_oe,
  // enable and reset pin
  input  wire logic                        chip_on_reset_pin,
  // applied settings
  output      logic                        standby_request_bit,
  output      logic [cdvsp_pkg::CODE_W-1:0] current_code,
  output      logic [cdvsp_pkg::SEL_W-1:0]  step_increment_code,
  output      logic [cdvsp_pkg::SEL_W-1:0]  step_period_code,
  output      logic [cdvsp_pkg::STEP_PER_W-1:0] step_period_cycles,
  // status
  output      logic                        drive_active,
  output      logic                        frame_applied
);
  import cdvsp_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisation and edges
  // ---------------------------------------------------------------
  logic [2:0] pins_s;
  logic       scl_s, sda_s, ena_s;
  logic       scl_p_r, sda_p_r;
  logic       scl_rise, scl_fall, start_ev, stop_ev;
  cdvsp_sync #(.WIDTH (3)) cdvsp_sync_inst (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({chip_on_reset_pin, sda_in, scl_in}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign ena_s = pins_s[2];
  assign scl_rise = scl_s & ~scl_p_r;
  assign scl_fall = ~scl_s & scl_p_r;
  assign start_ev = scl_s & scl_p_r & sda_p_r & ~sda_s;
  assign stop_ev  = scl_s & scl_p_r & ~sda_p_r & sda_s;

  // ---------------------------------------------------------------
  // receiver state
  // ---------------------------------------------------------------
  cdvsp_state_t      state_r, state_nxt;
  logic [2:0]        bit_r, bit_nxt;
  logic              got8_r, got8_nxt;
  logic [1:0]        byte_r, byte_nxt;
  logic [7:0]        shift_r, shift_nxt;
  logic [7:0]        b2_r, b2_nxt, b3_r, b3_nxt;
  logic              oe_r, oe_nxt;
  logic              commit;
  logic              addr_ok;
  assign addr_ok = (shift_r == {TARGET_ADDR, DIR_WRITE});
  always_comb
  begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    got8_nxt  = got8_r;
    byte_nxt  = byte_r;
    shift_nxt = shift_r;
    b2_nxt    = b2_r;
    b3_nxt    = b3_r;
    oe_nxt    = oe_r;
    commit    = 1'b0;
    if (!ena_s)
    begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end
    // start opens a frame, also repeated
    else if (start_ev)
    begin
      state_nxt = ST_RECV;
      bit_nxt   = 3'h0;
      got8_nxt  = 1'b0;
      byte_nxt  = 2'h0;
      oe_nxt    = 1'b0;
    end
    else if (stop_ev)
    begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end
    else
    begin
      case (state_r)
        ST_RECV:
        begin
          if (scl_rise && !got8_r)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_nxt   = bit_r + 3'h1;
            got8_nxt  = (bit_r == 3'h7);
          end
          else if (scl_fall && got8_r)
          begin
            got8_nxt = 1'b0;
            if (byte_r == 2'h0 && !addr_ok)
              state_nxt = ST_SKIP;
            else
            begin
              state_nxt = ST_ACK;
              oe_nxt    = 1'b1;
              if (byte_r == 2'h1)
                b2_nxt = shift_r;
              if (byte_r == 2'h2)
                b3_nxt = shift_r;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            oe_nxt    = 1'b0;
            commit    = (byte_r == 2'(CFG_BYTES));
            byte_nxt  = (byte_r == 2'(CFG_BYTES)) ? byte_r : byte_r + 2'h1;
            state_nxt = (byte_r == 2'(CFG_BYTES)) ? ST_SKIP : ST_RECV;
          end
        end
        ST_IDLE, ST_SKIP:
          oe_nxt = 1'b0;
        default:
        begin
          state_nxt = ST_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      state_r <= ST_IDLE;
      bit_r   <= 3'h0;
      got8_r  <= 1'b0;
      byte_r  <= 2'h0;
      shift_r <= 8'h00;
      b2_r    <= 8'h00;
      b3_r    <= 8'h00;
      oe_r    <= 1'b0;
    end
    else
    begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
      state_r <= state_nxt;
      bit_r   <= bit_nxt;
      got8_r  <= got8_nxt;
      byte_r  <= byte_nxt;
      shift_r <= shift_nxt;
      b2_r    <= b2_nxt;
      b3_r    <= b3_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  logic                  stby_r, stby_nxt;
  logic [CODE_W-1:0]     code_r, code_nxt;
  logic [SEL_W-1:0]      size_r, size_nxt, time_r, time_nxt;
  logic [STEP_PER_W-1:0] per_r, per_nxt;
  logic                  act_r, act_nxt;
  logic                  done_r;

  always_comb
  begin
    stby_nxt = stby_r;
    code_nxt = code_r;
    size_nxt = size_r;
    time_nxt = time_r;
    if (!ena_s)
    begin
      stby_nxt = STANDBY_RST;
      code_nxt = CODE_RST;
      size_nxt = SEL_RST;
      time_nxt = SEL_RST;
    end
    else if (commit)
    begin
      stby_nxt = b2_r[STANDBY_POS];
      code_nxt = {b2_r[CODE_HI_MSB:0], b3_r[CODE_LO_MSB:CODE_LO_LSB]};
      size_nxt = shift_r[SIZE_MSB:SIZE_LSB];
      time_nxt = shift_r[TIME_MSB:TIME_LSB];
    end
    per_nxt = STEP_PER_W'(STEP_BASE_CYC) << time_r;
    // any off condition forces output off
    act_nxt = ena_s & ~stby_r & (code_r != CODE_RST);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stby_r <= STANDBY_RST;
      code_r <= CODE_RST;
      size_r <= SEL_RST;
      time_r <= SEL_RST;
      per_r  <= STEP_PER_W'(STEP_BASE_CYC);
      act_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      stby_r <= stby_nxt;
      code_r <= code_nxt;
      size_r <= size_nxt;
      time_r <= time_nxt;
      per_r  <= per_nxt;
      act_r  <= act_nxt;
      done_r <= commit & ena_s;
    end
  end

  assign sda_out             = 1'b0;
  assign sda_oe              = oe_r;
  assign standby_request_bit = stby_r;
  assign current_code        = code_r;
  assign step_increment_code = size_r;
  assign step_period_code    = time_r;
  assign step_period_cycles  = per_r;
  assign drive_active        = act_r;
  assign frame_applied       = done_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cdvsp_cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_byte_end;
    state_r == ST_RECV && got8_r && scl_fall && ena_s && !start_ev
      && !stop_ev;
  endsequence
  sequence s_ack_end;
    state_r == ST_ACK && scl_fall && ena_s && !start_ev && !stop_ev;
  endsequence
  property p_ack_drive;
    s_byte_end ##0 (byte_r != 2'h0 || addr_ok) |=> sda_oe && state_r == ST_ACK;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("no ack");
  property p_release;
    s_ack_end |=> !sda_oe;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_refuse;
    s_byte_end ##0 (byte_r == 2'h0 && !addr_ok) |=> !sda_oe [*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("foreign ack");
  property p_start;
    start_ev && ena_s |=> state_r == ST_RECV && bit_r == 3'h0
      && byte_r == 2'h0;
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop;
    stop_ev && !start_ev |=> state_r == ST_IDLE && !sda_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_write_only;
    sda_oe |-> $past(state_nxt) == ST_ACK;
  endproperty
  a_write_only: assert property (p_write_only) else $error("stray oe");
  property p_ena_clear;
    !ena_s |=> current_code == CODE_RST && !standby_request_bit
      ##1 !drive_active;
  endproperty
  a_ena_clear: assert property (p_ena_clear) else $error("not cleared");
  property p_off;
    (!ena_s || stby_r || code_r == CODE_RST) |=> !drive_active;
  endproperty
  a_off: assert property (p_off) else $error("output on while off");
  property p_commit;
    commit && ena_s |=> current_code == {$past(b2_r[5:0]), $past(b3_r[7:4])}
      && step_period_code == $past(shift_r[4:2]) && frame_applied;
  endproperty
  a_commit: assert property (p_commit) else $error("not applied");
  property p_period;
    ##1 step_period_cycles == (STEP_PER_W'(STEP_BASE_CYC)
      << $past(step_period_code));
  endproperty
  a_period: assert property (p_period) else $error("bad period");
endmodule

//--- cdvsp_pkg.sv
// cdvsp_pkg: constants shared by the coil driver serial write port
// assumes a 25 MHz system clock
package cdvsp_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int STEP_BASE_NS    = 32000;
  localparam int STEP_BASE_CYC   = STEP_BASE_NS / CLK_PERIOD_NS;
  localparam int STEP_PER_W      = 17;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR    = 7'h33;
  localparam logic       DIR_WRITE      = 1'b0;
  localparam int         BYTE_BITS      = 8;
  localparam int         CFG_BYTES      = 3;
  localparam int         STANDBY_POS    = 7;
  localparam int         CODE_HI_MSB    = 5;
  localparam int         CODE_LO_MSB    = 7;
  localparam int         CODE_LO_LSB    = 4;
  localparam int         SIZE_MSB       = 7;
  localparam int         SIZE_LSB       = 5;
  localparam int         TIME_MSB       = 4;
  localparam int         TIME_LSB       = 2;
  localparam int         CODE_W         = 10;
  localparam int         SEL_W          = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic              STANDBY_RST = 1'b0;
  localparam logic [CODE_W-1:0] CODE_RST    = 10'h000;
  localparam logic [SEL_W-1:0]  SEL_RST     = 3'h0;

  // ---------------------------------------------------------------
  // receiver states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_ACK  = 2'b10,
    ST_SKIP = 2'b11
  } cdvsp_state_t;

endpackage

//--- cdvsp_sync.sv
// cdvsp_sync: two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clock
`timescale 1ns/1ps
module cdvsp_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // ---------------------------------------------------------------
  // two stages per bit
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
        begin
          meta_r[i]   <= 1'b1;
          sync_out[i] <= 1'b1;
        end
        else
        begin
          meta_r[i]   <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule

//--- cdvsp_ctrl_model.sv
// cdvsp_ctrl_model: bus controller writing frames
// assumes pull-up on data; clock low 5 clocks, high 3
`timescale 1ns/1ps
module cdvsp_ctrl_model (
  // clock
  input  wire logic clock,
  // serial pins
  input  wire logic sda,
  output      logic scl,
  output      logic sda_pull
);
  // ---------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------
  // idle lines high
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic pulse(output logic seen);
    wait_clk(4);
    scl = 1'b1;
    wait_clk(1);
    seen = sda;
    wait_clk(2);
    scl = 1'b0;
    wait_clk(1);
  endtask

  task automatic start();
    sda_pull = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(2);
    sda_pull = 1'b1;
    wait_clk(4);
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_pull = 1'b0;
    wait_clk(4);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull = ~b[i];
      pulse(seen);
    end
    sda_pull = 1'b0;
    pulse(seen);
    ack = ~seen;
  endtask
endmodule

//--- cdvsp_top_tb_top.sv
// cdvsp_top_tb_top: self-checking bench for the serial write port
// assumes the controller model of cdvsp_ctrl_model.sv
`timescale 1ns/1ps
module cdvsp_top_tb_top;
  import cdvsp_pkg::*;
  logic                  clock;
  logic                  rstn;
  logic                  scl;
  logic                  sda_pull;
  logic                  sda;
  logic                  chip_on_reset_pin;
  logic                  sda_out;
  logic                  sda_oe;
  logic                  standby_request_bit;
  logic [CODE_W-1:0]     current_code;
  logic [SEL_W-1:0]      step_increment_code;
  logic [SEL_W-1:0]      step_period_code;
  logic [STEP_PER_W-1:0] step_period_cycles;
  logic                  drive_active;
  logic                  frame_applied;
  int                    n_errors = 0;
  int                    checks = 0;
  int                    n_applied = 0;
  logic                  e_sb;
  logic [CODE_W-1:0]     e_code;
  logic [SEL_W-1:0]      e_sz;
  logic [SEL_W-1:0]      e_tm;

  // open-drain data wire with pull-up
  assign sda = ~(sda_pull | (sda_oe & ~sda_out));

  cdvsp_top cdvsp_top_inst (
    .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_on_reset_pin(chip_on_reset_pin),
    .standby_request_bit(standby_request_bit),
    .current_code(current_code),
    .step_increment_code(step_increment_code),
    .step_period_code(step_period_code),
    .step_period_cycles(step_period_cycles),
    .drive_active(drive_active), .frame_applied(frame_applied)
  );

  cdvsp_ctrl_model cdvsp_ctrl_model_inst (
    .clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull)
  );

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
    if (frame_applied === 1'b1)
      n_applied++;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic exp_state();
    logic act;
    act = chip_on_reset_pin & ~e_sb & (e_code != 10'h000);
    check("standby", standby_request_bit, e_sb);
    check("code", current_code, e_code);
    check("size", step_increment_code, e_sz);
    check("time", step_period_code, e_tm);
    check("period", step_period_cycles, STEP_BASE_CYC << e_tm);
    check("active", drive_active, act);
  endtask

  task automatic send(input logic [7:0] adr, input logic sb,
                      input logic [9:0] code, input logic [2:0] sz,
                      input logic [2:0] tm, input int nb,
                      output logic [4:0] acks);
    logic [7:0] b [5];
    logic a;
    b = '{adr, {sb, 1'b1, code[9:4]}, {code[3:0], 4'hA},
          {sz, tm, 2'b01}, 8'h00};
    acks = 5'h00;
    cdvsp_ctrl_model_inst.start();
    for (int i = 0; i < nb; i++)
    begin
      cdvsp_ctrl_model_inst.put_byte(b[i], a);
      acks[i] = a;
      cdvsp_ctrl_model_inst.wait_clk(4);
      check("ack_release", sda_oe, 1'b0);
    end
    cdvsp_ctrl_model_inst.stop();
    cdvsp_ctrl_model_inst.wait_clk(6);
  endtask

  task automatic good(input logic sb, input logic [9:0] code,
                      input logic [2:0] sz, input logic [2:0] tm,
                      input int nb);
    logic [4:0] acks;
    int n0;
    n0 = n_applied;
    send(8'h66, sb, code, sz, tm, nb, acks);
    check("acks", acks, 5'h0F);
    check("applied", n_applied, n0 + 1);
    e_sb = sb;
    e_code = code;
    e_sz = sz;
    e_tm = tm;
    exp_state();
  endtask

  task automatic bad(input logic [7:0] adr, input int nb,
                     input logic [4:0] ea);
    logic [4:0] acks;
    int n0;
    n0 = n_applied;
    send(adr, 1'b1, 10'h155, 3'h5, 3'h2, nb, acks);
    check("acks", acks, ea);
    check("applied", n_applied, n0);
    exp_state();
  endtask

  task automatic t_reset();
    {e_sb, e_code, e_sz, e_tm} = '0;
    exp_state();
    check("oe_idle", sda_oe, 1'b0);
    check("od_value", sda_out, 1'b0);
  endtask

  task automatic t_codes();
    good(1'b0, 10'h000, 3'h0, 3'h0, 4);
    for (int t = 0; t < 8; t++)
      good(1'b0, 10'h3FF >> t, 3'(7 - t), 3'(t), 4);
    good(1'b0, 10'h201, 3'h3, 3'h6, 5);
    good(1'b1, 10'h3FF, 3'h1, 3'h1, 4);
  endtask

  task automatic t_refuse();
    bad(8'h67, 4, 5'h00);
    bad(8'h64, 4, 5'h00);
    bad(8'hE6, 4, 5'h00);
    bad(8'h66, 3, 5'h07);
  endtask

  task automatic t_enable();
    chip_on_reset_pin = 1'b0;
    cdvsp_ctrl_model_inst.wait_clk(8);
    {e_sb, e_code, e_sz, e_tm} = '0;
    exp_state();
    chip_on_reset_pin = 1'b1;
    cdvsp_ctrl_model_inst.wait_clk(8);
    good(1'b0, 10'h0AA, 3'h2, 3'h4, 4);
  endtask

  task automatic t_restart();
    logic a;
    int n0;
    n0 = n_applied;
    cdvsp_ctrl_model_inst.start();
    cdvsp_ctrl_model_inst.put_byte(8'h66, a);
    check("ack_first", a, 1'b1);
    cdvsp_ctrl_model_inst.put_byte(8'h00, a);
    check("ack_second", a, 1'b1);
    cdvsp_ctrl_model_inst.wait_clk(4);
    check("applied", n_applied, n0);
    good(1'b0, 10'h123, 3'h7, 3'h3, 4);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rstn = 1'b0;
    chip_on_reset_pin = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    rstn = 1'b1;
    cdvsp_ctrl_model_inst.wait_clk(6);
    t_reset();
    t_codes();
    t_refuse();
    t_restart();
    t_enable();
    finish_test();
  end

  initial
  begin
    #2000000;
    n_errors++;
    finish_test();
  end
endmodule
